// ---- hdl/forward_converter_pwm_logic.sv ----
// Purpose: Cycle clock, current-mode latch and gate sequencing for a
//          dual-switch forward converter, with fault and lockout blocking
// Assumes: Comparator and lockout inputs arrive as digital levels,
//          asynchronous to core_clk; analog parts live outside
// Notes on behaviour
// - Oscillator toggles flip-flop into cycle clock
// - Cycle clock rise starts primary turn-on
// - Current trip ends primaries, enables rectifier
// - Cycle clock fall forces primaries off
// - Ignore current trip during gate blanking
// - Runaway current stops switching within 130ns
// - Runaway detection active during blanking too
// - Runaway current resets soft-start state
// - Rectifier gate opposite to low primary
// - Rectifier changes 150ns ahead of turn-on
// - Low gate on after, off before high
// - Supply lockout holds all gates inactive
// - High gate waits for boost supply
// - Peak sense capped at 150mV
// - Any system fault disables switching
// - Restart only through soft-start sequence
// - External sync sets cycle phase, to 350kHz
// - Both sync edges restart the oscillator
// - Sync rise starts cycle, fall forces off
// - Fault latched until soft-start discharged
// - Overvoltage or thermal trip resets soft-start

`timescale 1ns/1ns

module forward_converter_pwm_logic
#(
	parameter int OSC_TICKS = fwd_pwm_pkg::OSC_TICKS_DEF
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Comparator inputs
	input wire logic current_sense_amp,
	input wire logic current_cap_in,
	input wire logic runaway_current_in,
	input wire logic blank_gate_sense_in,
	// Lockouts and faults
	input wire logic supply_lockout,
	input wire logic boost_lockout,
	input wire logic input_overvoltage_in,
	input wire logic thermal_trip_in,
	input wire logic ref_overcurrent_in,
	input wire logic shutdown_in,
	input wire logic soft_start_low_in,
	// External phase lock
	input wire logic sync_in,
	// Gate drives
	output logic high_primary_gate_out,
	output logic low_primary_gate_out,
	output logic rectifier_gate_out,
	// Status
	output logic cycle_clk_out,
	output logic general_fault,
	output logic soft_start_reset_out
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [fwd_pwm_pkg::IN_N-1:0] raw_in;
	logic [fwd_pwm_pkg::IN_N-1:0] sync;

	assign raw_in = {sync_in, soft_start_low_in, shutdown_in, ref_overcurrent_in,
		thermal_trip_in, input_overvoltage_in, boost_lockout, supply_lockout,
		blank_gate_sense_in, current_cap_in, current_sense_amp};

	genvar gi;
	generate
		for (gi = 0; gi < fwd_pwm_pkg::IN_N; gi++)
		begin : g_sync
			// Each bit keeps its own flops so no vector has two writers
			logic stage1;
			logic stage2;

			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end
				else
				begin
					stage1 <= raw_in[gi];
					stage2 <= stage1;
				end
			end

			assign sync[gi] = stage2;
		end
	endgenerate

	logic trip_s;
	logic cap_s;
	logic blank_ok_s;
	logic supply_low_s;
	logic boost_low_s;
	logic sync_s;
	logic sync_d;
	logic sync_rise;
	logic sync_fall;

	assign trip_s = sync[fwd_pwm_pkg::IN_TRIP];
	assign cap_s = sync[fwd_pwm_pkg::IN_CAP];
	assign blank_ok_s = sync[fwd_pwm_pkg::IN_BLANK];
	assign supply_low_s = sync[fwd_pwm_pkg::IN_SUPPLY];
	assign boost_low_s = sync[fwd_pwm_pkg::IN_BOOST];
	assign sync_s = sync[fwd_pwm_pkg::IN_SYNC];

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sync_d <= 1'b0;
		else
			sync_d <= sync_s;
	end

	assign sync_rise = sync_s & ~sync_d;
	assign sync_fall = ~sync_s & sync_d;

	////////////////////////////////////////////////////////////////////////
	// Oscillator and cycle clock

	localparam logic [fwd_pwm_pkg::OSC_W-1:0] OSC_LAST = fwd_pwm_pkg::OSC_W'(OSC_TICKS - 1);

	logic [fwd_pwm_pkg::OSC_W-1:0] osc_cnt;
	logic osc_tick;
	logic cycle_clk;
	logic next_cycle_clk;
	logic cyc_rise;
	logic cyc_fall;

	assign osc_tick = (osc_cnt == OSC_LAST);

	// Either sync edge restarts the ramp, so the oscillator runs at twice
	// the sync rate and never fires just after a forced phase change
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			osc_cnt <= '0;
		else if (sync_rise || sync_fall || osc_tick)
			osc_cnt <= '0;
		else
			osc_cnt <= osc_cnt + 1'b1;
	end

	always_comb
	begin
		if (sync_rise)
			next_cycle_clk = 1'b1;
		else if (sync_fall)
			next_cycle_clk = 1'b0;
		else if (osc_tick)
			next_cycle_clk = ~cycle_clk;
		else
			next_cycle_clk = cycle_clk;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			cycle_clk <= 1'b0;
		else
			cycle_clk <= next_cycle_clk;
	end

	assign cyc_rise = next_cycle_clk & ~cycle_clk;
	assign cyc_fall = ~next_cycle_clk & cycle_clk;
	assign cycle_clk_out = cycle_clk;

	////////////////////////////////////////////////////////////////////////
	// Fault latch

	logic fault_now;
	logic block;

	// Runaway is read raw so shutdown is not slowed by the synchroniser
	assign fault_now = supply_low_s | sync[fwd_pwm_pkg::IN_INPUT_OVERVOLTAGE_IN]
		| sync[fwd_pwm_pkg::IN_THERMAL_TRIP_IN] | sync[fwd_pwm_pkg::IN_REFOC]
		| sync[fwd_pwm_pkg::IN_SHDN] | runaway_current_in;

	// Set wins over the discharge clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			general_fault <= fwd_pwm_pkg::FAULT_RESET;
		else if (fault_now)
			general_fault <= 1'b1;
		else if (sync[fwd_pwm_pkg::IN_SSLOW])
			general_fault <= 1'b0;
	end

	assign soft_start_reset_out = general_fault;
	assign block = general_fault | fault_now | runaway_current_in;

	////////////////////////////////////////////////////////////////////////
	// Current latch and gate sequencer

	logic pwm_latch;
	logic trip_ok;
	logic stop;
	logic [fwd_pwm_pkg::LEAD_W-1:0] lead_cnt;
	fwd_pwm_pkg::gate_state_t state;

	// Cap comparator ends the pulse even if the error level asks for more
	assign trip_ok = (trip_s | cap_s) & blank_ok_s;
	assign stop = ~pwm_latch | trip_ok | cyc_fall;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pwm_latch <= 1'b0;
		else if (cyc_rise)
			pwm_latch <= 1'b1;
		else if (trip_ok || cyc_fall)
			pwm_latch <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			lead_cnt <= '0;
		else if (state == fwd_pwm_pkg::S_LEAD)
			lead_cnt <= lead_cnt + 1'b1;
		else
			lead_cnt <= '0;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= fwd_pwm_pkg::S_OFF;
		else if (block)
			state <= fwd_pwm_pkg::S_OFF;
		else
		begin
			case (state)
				fwd_pwm_pkg::S_OFF:
					if (cyc_rise)
						state <= fwd_pwm_pkg::S_LEAD;
				fwd_pwm_pkg::S_LEAD:
					if (cyc_fall)
						state <= fwd_pwm_pkg::S_OFF;
					else if (lead_cnt == fwd_pwm_pkg::LEAD_LAST)
						state <= fwd_pwm_pkg::S_HIGH;
				fwd_pwm_pkg::S_HIGH:
					if (stop)
						state <= fwd_pwm_pkg::S_DROP;
					else
						state <= fwd_pwm_pkg::S_ON;
				fwd_pwm_pkg::S_ON:
					if (stop)
						state <= fwd_pwm_pkg::S_DROP;
				fwd_pwm_pkg::S_DROP:
					state <= fwd_pwm_pkg::S_OFF;
				default:
					state <= fwd_pwm_pkg::S_OFF;
			endcase
		end
	end

	// Outputs are registered; the raw runaway term still lands in one edge
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			high_primary_gate_out <= 1'b0;
			low_primary_gate_out <= 1'b0;
			rectifier_gate_out <= 1'b0;
		end
		else
		begin
			high_primary_gate_out <= !block && !boost_low_s
				&& (state == fwd_pwm_pkg::S_HIGH || state == fwd_pwm_pkg::S_ON
				|| state == fwd_pwm_pkg::S_DROP);
			// Low gate needs the high gate already on, so a boost lockout
			// cannot leave it switching alone
			low_primary_gate_out <= !block && !boost_low_s && high_primary_gate_out
				&& state == fwd_pwm_pkg::S_ON;
			// Rectifier drops first in the lead window, so both may be off
			rectifier_gate_out <= !block && !supply_low_s
				&& (state == fwd_pwm_pkg::S_OFF || state == fwd_pwm_pkg::S_DROP);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_turn_on;
		$fell(rectifier_gate_out) && !block ##1 !block [*3];
	endsequence

	sequence s_high_first;
		$rose(high_primary_gate_out) ##1 $rose(low_primary_gate_out);
	endsequence

	a_runaway_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
		runaway_current_in |=> !high_primary_gate_out && !low_primary_gate_out)
		else $error("runaway did not stop primaries");

	a_runaway_soft: assert property (@(posedge core_clk) disable iff (!rst_n)
		runaway_current_in |=> soft_start_reset_out)
		else $error("runaway did not reset soft-start");

	a_rect_oppose: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(rectifier_gate_out && low_primary_gate_out))
		else $error("rectifier and low gate both on");

	a_rect_lead: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_turn_on |-> !high_primary_gate_out)
		else $error("high gate within rectifier lead time");

	a_low_lags: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(low_primary_gate_out) |-> $past(high_primary_gate_out))
		else $error("low gate on before high gate");

	a_low_leads: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(high_primary_gate_out) && !$past(block) |-> !$past(low_primary_gate_out))
		else $error("high gate off before low gate");

	a_supply_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		supply_low_s |=> !rectifier_gate_out && !high_primary_gate_out
		&& !low_primary_gate_out)
		else $error("gate active under supply lockout");

	a_boost_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		boost_low_s |=> !high_primary_gate_out)
		else $error("high gate on under boost lockout");

	a_fall_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		cyc_fall |-> ##[1:2] !low_primary_gate_out ##1 !high_primary_gate_out)
		else $error("primaries not off after cycle fall");

	a_fault_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		general_fault && !sync[fwd_pwm_pkg::IN_SSLOW] |=> general_fault)
		else $error("fault cleared before soft-start discharge");

	a_rise_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		cyc_rise && !block && state == fwd_pwm_pkg::S_OFF |=> state == fwd_pwm_pkg::S_LEAD)
		else $error("cycle rise did not start turn-on");

	a_order_on: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(high_primary_gate_out) && state == fwd_pwm_pkg::S_ON && !block
		&& !stop |-> ##1 low_primary_gate_out)
		else $error("low gate did not follow high gate");

endmodule

// ---- hdl/fwd_pwm_pkg.sv ----
// Purpose: Shared constants for the forward converter PWM logic
// Assumes: core_clk at 25 MHz
// Notes: Times are kept as printed; cycle counts derive from them

package fwd_pwm_pkg;

	localparam int CLK_PERIOD_NS = 40;

	// Runaway shutdown is a longest time: round down, at least one cycle
	localparam int RUNAWAY_DELAY_NS = 130;
	localparam int RUNAWAY_CYCLES_RAW = RUNAWAY_DELAY_NS / CLK_PERIOD_NS;
	localparam int RUNAWAY_CYCLES = (RUNAWAY_CYCLES_RAW < 1) ? 1 : RUNAWAY_CYCLES_RAW;

	// Rectifier lead is a least time: round up
	localparam int RECT_LEAD_NS = 150;
	localparam int RECT_LEAD_CYCLES = (RECT_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LEAD_W = 4;
	localparam logic [LEAD_W-1:0] LEAD_LAST = LEAD_W'(RECT_LEAD_CYCLES - 1);

	// Oscillator half of the cycle clock, in core_clk cycles
	localparam int OSC_TICKS_DEF = 42;
	localparam int OSC_W = 12;

	// Synchronised input bit positions
	localparam int IN_TRIP = 0;
	localparam int IN_CAP = 1;
	localparam int IN_BLANK = 2;
	localparam int IN_SUPPLY = 3;
	localparam int IN_BOOST = 4;
	localparam int IN_INPUT_OVERVOLTAGE_IN = 5;
	localparam int IN_THERMAL_TRIP_IN = 6;
	localparam int IN_REFOC = 7;
	localparam int IN_SHDN = 8;
	localparam int IN_SSLOW = 9;
	localparam int IN_SYNC = 10;
	localparam int IN_N = 11;

	localparam logic FAULT_RESET = 1'b1;

	typedef enum logic [2:0]
	{
		S_OFF = 3'b000,
		S_LEAD = 3'b001,
		S_HIGH = 3'b010,
		S_ON = 3'b011,
		S_DROP = 3'b100
	} gate_state_t;

endpackage

// ---- tb/fwd_far_side.sv ----
// Purpose: Far side of the PWM logic: gate charge, sense and cap comparators
// Assumes: Outputs move 2 ns after core_clk rises, like the bench stimulus
// Notes: Trip timing and a stuck-gate mode are commanded by the bench

`timescale 1ns/1ns

module fwd_far_side
(
	// Clock
	input wire logic core_clk,
	// Gate drive seen
	input wire logic low_primary_gate_out,
	// Scenario controls
	input wire logic [3:0] trip_after,
	input wire logic use_cap,
	input wire logic blank_stuck,
	// Comparators and gate sense
	output logic current_sense_amp,
	output logic current_cap_in,
	output logic blank_gate_sense_in
);
	logic [1:0] gate_ramp = 2'h0;
	int on_cycles = 0;
	logic trip;

	////////////////////////////////////////////////////////////////
	// Gate takes two cycles to enhance; current ramps while it is on
	always @(posedge core_clk)
	begin
		#2;
		gate_ramp <= {gate_ramp[0], low_primary_gate_out};
		on_cycles <= low_primary_gate_out ? on_cycles + 1 : 0;
	end

	assign trip = (trip_after != 4'h0) && (on_cycles >= trip_after + 2);
	// A stuck gate never reaches full enhancement
	assign blank_gate_sense_in = gate_ramp[1] & ~blank_stuck;
	assign current_sense_amp = trip & ~use_cap;
	assign current_cap_in = trip & use_cap;
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the forward converter PWM logic
// Assumes: Short oscillator count so runs stay brief
// Notes: Random trip timing comes from a fixed-seed shift register

`timescale 1ns/1ns

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end

module tb_top;
	localparam int TICKS = 24;
	logic core_clk, rst_n, runaway_current_in, boost_lockout, soft_start_low_in, sync_in;
	logic [4:0] flt;
	logic current_sense_amp, current_cap_in, blank_gate_sense_in, use_cap, blank_stuck;
	logic high_primary_gate_out, low_primary_gate_out, rectifier_gate_out;
	logic cycle_clk_out, general_fault, soft_start_reset_out;
	logic [3:0] trip_after;
	logic [31:0] lfsr = 32'h91ff;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int n, seen;

	forward_converter_pwm_logic #(.OSC_TICKS(TICKS)) DUT (.core_clk(core_clk), .rst_n(rst_n),
		.current_sense_amp(current_sense_amp), .current_cap_in(current_cap_in),
		.runaway_current_in(runaway_current_in), .blank_gate_sense_in(blank_gate_sense_in),
		.supply_lockout(flt[0]), .boost_lockout(boost_lockout),
		.input_overvoltage_in(flt[1]), .thermal_trip_in(flt[2]),
		.ref_overcurrent_in(flt[3]), .shutdown_in(flt[4]),
		.soft_start_low_in(soft_start_low_in), .sync_in(sync_in),
		.high_primary_gate_out(high_primary_gate_out),
		.low_primary_gate_out(low_primary_gate_out), .rectifier_gate_out(rectifier_gate_out),
		.cycle_clk_out(cycle_clk_out), .general_fault(general_fault),
		.soft_start_reset_out(soft_start_reset_out));

	fwd_far_side far (.core_clk(core_clk), .low_primary_gate_out(low_primary_gate_out),
		.trip_after(trip_after), .use_cap(use_cap), .blank_stuck(blank_stuck),
		.current_sense_amp(current_sense_amp), .current_cap_in(current_cap_in),
		.blank_gate_sense_in(blank_gate_sense_in));

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// A trip ends the on-time early only when blanking has lifted
	function automatic logic trip_ends(input logic [3:0] after, input logic stuck);
		return (after != 4'h0) && !stuck;
	endfunction

	function automatic logic [4:0] outs();
		return {general_fault, cycle_clk_out, rectifier_gate_out, low_primary_gate_out,
			high_primary_gate_out};
	endfunction

	function automatic logic [2:0] gates();
		return {rectifier_gate_out, low_primary_gate_out, high_primary_gate_out};
	endfunction

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#2;
	endtask

	task automatic wait_for(input int i, input logic v, input int lim, output int k);
		logic [4:0] o;
		k = 0;
		o = outs();
		while (o[i] !== v && k < lim)
		begin
			tick(1);
			k++;
			o = outs();
		end
	endtask

	task automatic results();
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic clear_fault();
		soft_start_low_in = 1'b1;
		wait_for(4, 1'b0, 40, n);
		`CHK("fault_clear", 1'b0, soft_start_reset_out)
		soft_start_low_in = 1'b0;
	endtask

	task automatic cycle_start();
		wait_for(3, 1'b0, 60, n);
		wait_for(3, 1'b1, 60, n);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			num_errors++;
			results();
		end
	end

	always @(negedge core_clk)
	begin
		if (rst_n === 1'b1)
		begin
			`CHK("rect_and_low", 1'b0, rectifier_gate_out & low_primary_gate_out)
			`CHK("low_without_high", 1'b0, low_primary_gate_out & ~high_primary_gate_out)
		end
	end

	initial
	begin
		{rst_n, runaway_current_in, boost_lockout, soft_start_low_in, sync_in} = 5'h00;
		{flt, trip_after, use_cap, blank_stuck} = 11'h000;
		tick(4);
		rst_n = 1'b1;
		`CHK("gates_reset", 3'h0, gates())
		tick(10);
		`CHK("fault_held", 1'b1, general_fault)
		clear_fault();
		cycle_start();
		wait_for(3, 1'b0, 60, n);
		`CHK("half_high", 1'b1, n == TICKS)
		wait_for(3, 1'b1, 60, n);
		`CHK("half_low", 1'b1, n == TICKS)
		for (int i = 0; i < 12; i++)
		begin
			lfsr = next_rand(lfsr);
			trip_after = (i == 0) ? 4'h0 : 4'(lfsr[3:0] % 6 + 1);
			use_cap = lfsr[4];
			blank_stuck = (i % 4 == 3);
			cycle_start();
			wait_for(2, 1'b0, 8, n);
			wait_for(0, 1'b1, 8, n);
			`CHK("rect_lead", 1'b1, n == fwd_pwm_pkg::RECT_LEAD_CYCLES)
			`CHK("low_lags", 1'b0, low_primary_gate_out)
			wait_for(1, 1'b1, 4, n);
			`CHK("low_lag_len", 1'b1, n == 1)
			wait_for(1, 1'b0, 40, n);
			`CHK("rect_after", 1'b1, rectifier_gate_out)
			`CHK("high_stays", 1'b1, high_primary_gate_out)
			`CHK("end_cause", trip_ends(trip_after, blank_stuck), cycle_clk_out)
			tick(1);
			`CHK("high_off", 1'b0, high_primary_gate_out)
		end
		trip_after = 4'h0;
		// Runaway while the gate is still blanked
		cycle_start();
		wait_for(1, 1'b1, 20, n);
		runaway_current_in = 1'b1;
		wait_for(0, 1'b0, 4, n);
		`CHK("runaway_stop", 1'b1, n <= fwd_pwm_pkg::RUNAWAY_CYCLES)
		`CHK("runaway_low", 1'b0, low_primary_gate_out)
		`CHK("runaway_ss", 1'b1, soft_start_reset_out)
		runaway_current_in = 1'b0;
		clear_fault();
		for (int k = 0; k < 5; k++)
		begin
			cycle_start();
			wait_for(1, 1'b1, 20, n);
			flt = 5'(1 << k);
			wait_for(0, 1'b0, 5, n);
			`CHK("fault_stop", 1'b1, n <= 3)
			if (k > 0)
				`CHK("fault_latch", 1'b1, general_fault)
			tick(2 * TICKS);
			`CHK("fault_gates", 3'h0, gates())
			flt = 5'h00;
			tick(6);
			if (k > 0)
				`CHK("fault_wait_ss", 1'b1, general_fault)
			clear_fault();
		end
		boost_lockout = 1'b1;
		seen = 0;
		repeat (2 * TICKS + 4)
		begin
			tick(1);
			seen += int'(high_primary_gate_out);
		end
		`CHK("boost_block", 1'b1, seen == 0)
		boost_lockout = 1'b0;
		// Sync phases of 16 and 20 cycles, each under the free-run half
		for (int p = 0; p < 6; p++)
		begin
			if (p >= 2)
				`CHK("sync_phase", 1'b0, cycle_clk_out)
			sync_in = 1'b1;
			wait_for(3, 1'b1, 8, n);
			if (p >= 2)
				`CHK("sync_rise", 1'b1, n <= 4)
			tick(16 - n);
			if (p >= 2)
				`CHK("sync_on", 1'b1, high_primary_gate_out)
			sync_in = 1'b0;
			wait_for(0, 1'b0, 8, n);
			if (p >= 2)
				`CHK("sync_fall", 1'b1, n <= 5)
			tick(20 - n);
		end
		results();
	end
endmodule
